// ===== verilog/pscl_top.sv
// What this block does
// - In user mode request, status and load-complete are all high
// - Request driven low abandons user mode and starts reconfiguration
// - After power-up status stays low for the power-on delay
// - Load-complete stays low from power-up until loading finishes
// - Load-complete goes high only after every bit is received
// - Serial data pin becomes user I/O after configuration
// - Once its option bit is loaded as 1, startup-complete goes low until initialization ends
`timescale 1ns/1ps
`default_nettype none
module pscl_top #(
  parameter int IMAGE_BITS = pscl_pkg::IMAGE_BITS,
  parameter int POR_CYCLES = pscl_pkg::POR_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_config_req_n,
  input wire logic i_config_clock,
  input wire logic i_serial_config_in,
  input wire logic i_reconfig_strobe,
  input wire logic i_wdog_reset,
  input wire logic i_user_io_out,
  input wire logic i_user_io_oe,
  output logic o_status_n,
  output logic o_status_n_oe,
  output logic o_load_done,
  output logic o_load_done_oe,
  output logic o_init_done,
  output logic o_user_mode,
  output logic o_user_io_in,
  output logic o_data_pin_out,
  output logic o_data_pin_oe,
  output logic o_wdog_restart
);
  localparam int CW = $clog2(IMAGE_BITS + 1);
  localparam int PW = $clog2(POR_CYCLES + 1);
  localparam int SW = $clog2(pscl_pkg::STROBE_CYCLES + 1);

  // The option bit must fall inside the image and the trailing count must fit its counter
  if (IMAGE_BITS < 2 || POR_CYCLES < 1 || pscl_pkg::INIT_OPT_POS >= IMAGE_BITS ||
      pscl_pkg::TRAIL_EDGES > 3) begin : g_bad_params
    $error("pscl_top: parameter out of range");
  end

  typedef enum logic [2:0] {POR_HOLD, REQ_HOLD, LOADING, TRAILING, USER} pscl_state_e;
  pscl_state_e state_q, state_d;

  // Each link and strobe pin passes two flops, so link edges are seen two core cycles late
  logic req_n_s, clk_s, data_s, recfg_s, wdog_s;
  pscl_sync #(.WIDTH(5)) u_sync (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_async({i_config_req_n, i_config_clock, i_serial_config_in, i_reconfig_strobe, i_wdog_reset}),
    .o_sync({req_n_s, clk_s, data_s, recfg_s, wdog_s})
  );

  logic clk_prev_q, recfg_prev_q, wdog_prev_q;
  logic [PW-1:0] por_cnt_q;
  logic [CW-1:0] bit_cnt_q;
  logic [1:0] trail_q;
  logic init_opt_q, init_opt_seen_q;
  logic [SW-1:0] recfg_len_q, wdog_len_q;

  wire clk_rise = clk_s && !clk_prev_q;
  wire clk_fall = !clk_s && clk_prev_q;
  wire por_done = (por_cnt_q == PW'(POR_CYCLES));
  wire all_bits = (bit_cnt_q == CW'(IMAGE_BITS));
  wire trail_done = (trail_q == 2'(pscl_pkg::TRAIL_EDGES));
  // A strobe counts only if it stood long enough; short glitches are ignored
  wire recfg_ok = !recfg_s && recfg_prev_q && (recfg_len_q == SW'(pscl_pkg::STROBE_CYCLES));
  wire wdog_ok = !wdog_s && wdog_prev_q && (wdog_len_q == SW'(pscl_pkg::STROBE_CYCLES));
  wire reconfig = !req_n_s || recfg_ok;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      POR_HOLD: if (por_done) state_d = REQ_HOLD;
      REQ_HOLD: if (req_n_s) state_d = LOADING;
      LOADING: if (!req_n_s) state_d = REQ_HOLD;
        else if (all_bits) state_d = TRAILING;
      TRAILING: if (!req_n_s) state_d = REQ_HOLD;
        else if (trail_done) state_d = USER;
      USER: if (reconfig) state_d = REQ_HOLD;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= POR_HOLD;
      clk_prev_q <= 1'h0;
      recfg_prev_q <= 1'h0;
      wdog_prev_q <= 1'h0;
    end else begin
      state_q <= state_d;
      clk_prev_q <= clk_s;
      recfg_prev_q <= recfg_s;
      wdog_prev_q <= wdog_s;
    end
  end

  // Counts once per power-up only; a later request does not repeat the hold
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      por_cnt_q <= '0;
    end else if (state_q == POR_HOLD && !por_done) begin
      por_cnt_q <= por_cnt_q + PW'(1);
    end
  end

  // Bits are taken on the rising edge of the link clock while loading
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bit_cnt_q <= '0;
      init_opt_q <= pscl_pkg::INIT_OPT_RESET[0];
      init_opt_seen_q <= 1'h0;
    end else if (state_q != LOADING) begin
      if (state_q == REQ_HOLD) begin
        bit_cnt_q <= '0;
        init_opt_seen_q <= 1'h0;
      end
    end else if (clk_rise && !all_bits) begin
      bit_cnt_q <= bit_cnt_q + CW'(1);
      if (bit_cnt_q == CW'(pscl_pkg::INIT_OPT_POS)) begin
        init_opt_q <= data_s;
        init_opt_seen_q <= 1'h1;
      end
    end
  end

  // Falls are counted only after load-complete is released
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      trail_q <= '0;
    end else if (state_q != TRAILING) begin
      trail_q <= '0;
    end else if (clk_fall && !trail_done) begin
      trail_q <= trail_q + 2'h1;
    end
  end

  // Counters saturate so a long strobe cannot wrap and look short
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      recfg_len_q <= '0;
      wdog_len_q <= '0;
    end else begin
      if (!recfg_s) recfg_len_q <= '0;
      else if (recfg_len_q != SW'(pscl_pkg::STROBE_CYCLES)) recfg_len_q <= recfg_len_q + SW'(1);
      if (!wdog_s) wdog_len_q <= '0;
      else if (wdog_len_q != SW'(pscl_pkg::STROBE_CYCLES)) wdog_len_q <= wdog_len_q + SW'(1);
    end
  end

  wire user_d = (state_d == USER);
  wire status_low_d = (state_d == POR_HOLD) || (state_d == REQ_HOLD);
  wire opt_on = init_opt_seen_q && init_opt_q;
  // Startup-complete is driven as a plain level with no enable: low once enabled, high in user mode
  wire init_d = !opt_on || user_d;

  // Open-drain pins: the value stays low and the enable does the pulling
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_status_n <= 1'h0;
      o_status_n_oe <= 1'h1;
      o_load_done <= 1'h0;
      o_load_done_oe <= 1'h1;
      o_init_done <= 1'h1;
      o_user_mode <= 1'h0;
      o_user_io_in <= 1'h0;
      o_data_pin_out <= 1'h0;
      o_data_pin_oe <= 1'h0;
      o_wdog_restart <= 1'h0;
    end else begin
      o_status_n <= 1'h0;
      o_status_n_oe <= status_low_d;
      o_load_done <= 1'h0;
      o_load_done_oe <= (state_d == POR_HOLD) || (state_d == REQ_HOLD) || (state_d == LOADING);
      o_init_done <= init_d;
      o_user_mode <= user_d;
      o_user_io_in <= user_d && data_s;
      o_data_pin_out <= i_user_io_out;
      o_data_pin_oe <= user_d && i_user_io_oe;
      o_wdog_restart <= user_d && wdog_ok;
    end
  end

  // Pin-level checks; an enable high means the pin is pulled low
  a_status_por: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (state_q == POR_HOLD) |=> o_status_n_oe) else $error("status released during power-on hold");
  a_load_low: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (state_q == LOADING && !all_bits) |=> o_load_done_oe) else $error("load-complete released early");
  a_user_high: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    o_user_mode |-> (!o_status_n_oe && !o_load_done_oe)) else $error("pin low in user mode");
  a_req_exit: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (state_q == USER && !req_n_s) |=> (!o_user_mode && o_status_n_oe)) else $error("request ignored");
  a_trail_two: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (state_q == TRAILING && trail_q == 2'h0) |=> state_q != USER) else $error("user mode too soon");
  a_bit_step: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (state_q == LOADING && req_n_s && clk_rise && !all_bits) |=>
      bit_cnt_q == $past(bit_cnt_q) + CW'(1)) else $error("bit not counted");
  a_init_low: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (opt_on && state_q == TRAILING && !trail_done) |=> !o_init_done)
    else $error("startup-complete high early");
  a_data_user: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    o_data_pin_oe |-> o_user_mode) else $error("data pin driven while configuring");
  a_wdog_short: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    ($fell(wdog_s) && wdog_len_q < SW'(pscl_pkg::STROBE_CYCLES)) |=> !o_wdog_restart)
    else $error("short watchdog strobe accepted");
  a_recfg_short: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    ($fell(recfg_s) && recfg_len_q < SW'(pscl_pkg::STROBE_CYCLES) && state_q == USER && req_n_s)
    |=> o_user_mode) else $error("short reconfiguration strobe accepted");
  a_load_release: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (state_q == TRAILING) |-> !o_load_done_oe) else $error("load-complete held after all bits");
  a_init_user: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    o_user_mode |-> o_init_done) else $error("startup-complete low in user mode");
  a_io_idle: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    !o_user_mode |-> (!o_user_io_in && !o_data_pin_oe)) else $error("user pin active while loading");
  a_status_req: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (state_q == REQ_HOLD && !req_n_s) |=> o_status_n_oe) else $error("status released under request");
endmodule
`default_nettype wire

// ===== verilog/pscl_pkg.sv
`default_nettype none
package pscl_pkg;
  // Core clock period in ns
  localparam int CORE_CLK_NS = 100;
  // Power-on hold of the status output
  localparam int POR_DELAY_US = 100;
  localparam int POR_CYCLES = (POR_DELAY_US * 1000) / CORE_CLK_NS;
  // Minimum strobe width for reconfiguration and watchdog restart
  localparam int STROBE_MIN_NS = 250;
  localparam int STROBE_CYCLES = (STROBE_MIN_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  // Configuration image length in bits
  localparam int IMAGE_BITS = 64;
  // Falling edges after load-complete that start initialization
  localparam int TRAIL_EDGES = 2;
  // Bit position of the startup-complete enable option in the image
  localparam int INIT_OPT_POS = 0;
  localparam logic [1:0] INIT_OPT_RESET = 2'h0;
endpackage
`default_nettype wire

// ===== verilog/pscl_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pscl_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ===== sim/pscl_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pscl_host_model #(
  parameter int IMAGE_BITS = 8
) (
  input wire logic i_core_clk,
  input wire logic i_status_n,
  input wire logic i_load_done,
  output logic o_config_clock,
  output logic o_data
);
  initial {o_config_clock, o_data} = 2'h0;
  task automatic half();
    repeat (4) @(posedge i_core_clk);
  endtask
  // Clock rests high after the last bit, so no fall can precede load-complete
  task automatic send(input logic [IMAGE_BITS-1:0] img, input int n);
    wait (i_status_n === 1'b1);
    for (int i = 0; i < n; i++) begin
      o_data <= img[i];
      o_config_clock <= 1'b0;
      half();
      o_config_clock <= 1'b1;
      half();
    end
    // Released line shows the inverse, never a stale bit
    o_data <= ~img[n-1];
  endtask
  task automatic trail();
    wait (i_load_done === 1'b1);
    half();
    o_config_clock <= 1'b0;
    half();
    o_config_clock <= 1'b1;
    half();
    o_config_clock <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== sim/pscl_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module pscl_top_test;
  localparam int IMAGE_BITS = 8;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_n = 1'b1;
  logic strobe = 1'b0;
  logic wdog = 1'b0;
  logic uo = 1'b0;
  logic uoe = 1'b0;
  wire logic h_clk, h_dat, pin, st_oe, ld_oe, init_done, user, uin, pout, poe, wrst, stv, ldv;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  int wd_cnt = 0;
  logic exp_q[$];
  assign pin = poe ? pout : h_dat;
  always #50 clk = ~clk;
  pscl_top #(.IMAGE_BITS(IMAGE_BITS), .POR_CYCLES(5)) u_pscl_top (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_config_req_n(req_n), .i_config_clock(h_clk),
    .i_serial_config_in(pin), .i_reconfig_strobe(strobe), .i_wdog_reset(wdog),
    .i_user_io_out(uo), .i_user_io_oe(uoe), .o_status_n(stv), .o_status_n_oe(st_oe),
    .o_load_done(ldv), .o_load_done_oe(ld_oe), .o_init_done(init_done), .o_user_mode(user),
    .o_user_io_in(uin), .o_data_pin_out(pout), .o_data_pin_oe(poe), .o_wdog_restart(wrst));
  pscl_host_model #(.IMAGE_BITS(IMAGE_BITS)) u_pscl_host_model (
    .i_core_clk(clk), .i_status_n(!st_oe), .i_load_done(!ld_oe),
    .o_config_clock(h_clk), .o_data(h_dat));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wrst === 1'b1) wd_cnt <= wd_cnt + 1;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic sel(input int k);
    return k == 0 ? !ld_oe : (k == 1 ? user : !user);
  endfunction
  task automatic wait_hi(input int k);
    int c;
    c = 0;
    while (sel(k) !== 1'b1 && c < 100) begin
      tick(1);
      c++;
    end
    chk(sel(k), 1'b1);
  endtask
  task automatic load(input logic opt, input int n);
    logic [IMAGE_BITS-1:0] img;
    img = IMAGE_BITS'($urandom);
    img[0] = opt;
    exp_q = {};
    for (int i = 0; i < n; i++) exp_q.push_back(img[i]);
    u_pscl_host_model.send(img, n);
    chk(poe, 1'b0);
    if (n < IMAGE_BITS) begin
      tick(20);
      chk(ld_oe, 1'b1);
    end else begin
      wait_hi(0);
      chk(user, 1'b0);
      chk(init_done, !exp_q[0]);
      u_pscl_host_model.trail();
      wait_hi(1);
      chk(st_oe | ld_oe, 1'b0);
      chk(stv | ldv, 1'b0);
      chk(init_done, 1'b1);
    end
  endtask
  task automatic pulse(input int k, input int w);
    if (k == 0) strobe <= 1'b1;
    else wdog <= 1'b1;
    tick(w);
    strobe <= 1'b0;
    wdog <= 1'b0;
    tick(12);
  endtask
  task automatic test_done();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    int s;
    s = $urandom(84);
    tick(5);
    rst_n <= 1'b1;
    tick(2);
    chk(st_oe & ld_oe, 1'b1);
    load(1'b1, IMAGE_BITS);
    for (int i = 0; i < 4; i++) begin
      s = $urandom;
      uo <= s[0];
      uoe <= s[1];
      tick(6);
      chk(poe, s[1]);
      chk(uin, s[1] ? s[0] : h_dat);
      chk(pout, s[0]);
    end
    pulse(1, 2);
    chk(wd_cnt == 0, 1'b1);
    pulse(1, 4);
    chk(wd_cnt == 1, 1'b1);
    pulse(1, 3);
    chk(wd_cnt == 2, 1'b1);
    pulse(0, 2);
    chk(user, 1'b1);
    pulse(0, 4);
    wait_hi(2);
    load(1'b0, IMAGE_BITS);
    req_n <= 1'b0;
    wait_hi(2);
    tick(2);
    chk(st_oe & ld_oe, 1'b1);
    req_n <= 1'b1;
    load(1'b1, IMAGE_BITS - 1);
    test_done();
  end
endmodule
`default_nettype wire
